// ==== rdcs_pkg.sv ====
// register map, field layout and reset values of the redriver configuration bank
package rdcs_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_GEN_CTL   = 8'h0A;
  localparam logic [7:0] OFS_EQ_L1_L3  = 8'h10;
  localparam logic [7:0] OFS_EQ_L0_L2  = 8'h11;
  localparam logic [7:0] OFS_SNOOPED   = 8'h12;
  localparam logic [7:0] OFS_LANE_CTL  = 8'h13;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_GEN_CTL   = 8'h01;
  localparam logic [7:0] RST_EQ        = 8'h00;
  localparam logic [7:0] RST_LANE_CTL  = 8'h00;
  // ==========================================================
  // access masks: plain write bits per register, and an empty mask passed as set and clear
  localparam logic [7:0] RW_GEN_CTL    = 8'h1F;
  localparam logic [7:0] RW_EQ         = 8'hFF;
  localparam logic [7:0] RW_LANE_CTL   = 8'h8F;
  localparam logic [7:0] NO_BITS       = 8'h00;
  // ==========================================================
  // field positions
  localparam int GEN_EQ_SRC_BIT        = 4;
  localparam int GEN_DP_EN_SRC_BIT     = 3;
  localparam int GEN_HPD_FORCE_BIT     = 3;
  localparam int GEN_ORIENT_BIT        = 2;
  localparam int GEN_MUX_UPPER_BIT     = 1;
  localparam int LANE_SNOOP_DIS_BIT    = 7;
  localparam int SNP_POWER_LSB         = 5;
  // mux configuration encodings
  localparam logic [1:0] MUX_OFF       = 2'h0;
  localparam logic [1:0] MUX_USB       = 2'h1;
  localparam logic [1:0] MUX_DP4       = 2'h2;
  localparam logic [1:0] MUX_DP2_USB   = 2'h3;
  // lane mask for two-lane mode, and the strap settle count
  localparam logic [3:0] DP2_LANES     = 4'h3;
  localparam logic [1:0] STRAP_SETTLE  = 2'h2;
endpackage

// ==== rdcs_config_snoop_regs.sv ====
// configuration and sideband-snoop register bank of the redriver crosspoint
`timescale 1ns/1ps
`default_nettype none

module rdcs_config_snoop_regs (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic [1:0] displayportEqStraps,
  input  wire logic       displayportControlPin,
  input  wire logic       auxPowerWrite,
  input  wire logic [1:0] auxPowerData,
  input  wire logic       auxLaneCountWrite,
  input  wire logic [4:0] auxLaneCountData,
  output logic      [1:0] muxConfiguration,
  output logic            orientationSelect,
  output logic            hotPlugInputForce,
  output logic            eqSourceFromRegisters,
  output logic            usbEnable,
  output logic      [3:0] lane0EqLevel,
  output logic      [3:0] lane1EqLevel,
  output logic      [3:0] lane2EqLevel,
  output logic      [3:0] lane3EqLevel,
  output logic      [3:0] dpLaneEnable
);
  import rdcs_pkg::*;

  // ==========================================================
  // register write helper
  // apply write, set and clear masks
  function automatic logic [7:0] applyWrite(input logic [7:0] oldVal, input logic [7:0] wr,
                                            input logic [7:0] rwMask, input logic [7:0] setMask,
                                            input logic [7:0] clrMask);
    logic [7:0] v;
    v = (oldVal & ~rwMask) | (wr & rwMask);
    v = v | (wr & setMask);
    v = v & ~(wr & clrMask);
    return v;
  endfunction

  // ==========================================================
  // pin synchronisers and strap capture
  logic [1:0] strapMeta_r, strapSync_r;
  logic       pinMeta_r, pinSync_r;
  logic [1:0] strapSample_r, strapSample_nxt;
  logic [1:0] settleCnt_r, settleCnt_nxt;
  logic       strapDone_r, strapDone_nxt;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      strapMeta_r <= 2'h0;
      strapSync_r <= 2'h0;
      pinMeta_r   <= 1'b0;
      pinSync_r   <= 1'b0;
    end else begin
      strapMeta_r <= displayportEqStraps;
      strapSync_r <= strapMeta_r;
      pinMeta_r   <= displayportControlPin;
      pinSync_r   <= pinMeta_r;
    end
  end

  always_comb begin
    strapSample_nxt = strapSample_r;
    settleCnt_nxt   = settleCnt_r;
    strapDone_nxt   = strapDone_r;
    if (!strapDone_r) begin
      if (settleCnt_r == STRAP_SETTLE) begin
        strapSample_nxt = strapSync_r;
        strapDone_nxt   = 1'b1;
      end else begin
        settleCnt_nxt = settleCnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      strapSample_r <= 2'h0;
      settleCnt_r   <= 2'h0;
      strapDone_r   <= 1'b0;
    end else begin
      strapSample_r <= strapSample_nxt;
      settleCnt_r   <= settleCnt_nxt;
      strapDone_r   <= strapDone_nxt;
    end
  end

  // strap pair widened to a four-bit equaliser level
  logic [3:0] strapLevel;
  assign strapLevel = {2'h0, strapSample_r};

  // ==========================================================
  // software registers and snooped state
  logic [7:0] genCtl_r, genCtl_nxt;
  logic [7:0] eqL1L3_r, eqL1L3_nxt;
  logic [7:0] eqL0L2_r, eqL0L2_nxt;
  logic [7:0] laneCtl_r, laneCtl_nxt;
  logic [1:0] powerState_r, powerState_nxt;
  logic [4:0] laneCount_r, laneCount_nxt;
  logic       muxUpperFall;

  always_comb begin
    genCtl_nxt  = genCtl_r;
    eqL1L3_nxt  = eqL1L3_r;
    eqL0L2_nxt  = eqL0L2_r;
    laneCtl_nxt = laneCtl_r;
    if (regWrEn) begin
      case (regAddr)
        OFS_GEN_CTL:  genCtl_nxt  = applyWrite(genCtl_r, regWrData, RW_GEN_CTL, NO_BITS, NO_BITS);
        OFS_EQ_L1_L3: eqL1L3_nxt  = applyWrite(eqL1L3_r, regWrData, RW_EQ, NO_BITS, NO_BITS);
        OFS_EQ_L0_L2: eqL0L2_nxt  = applyWrite(eqL0L2_r, regWrData, RW_EQ, NO_BITS, NO_BITS);
        // snoop disable and lane off bits
        OFS_LANE_CTL: laneCtl_nxt = applyWrite(laneCtl_r, regWrData, RW_LANE_CTL, NO_BITS, NO_BITS);
        default: begin
        end
      endcase
    end
    // straps overwrite levels while override is clear
    if (!genCtl_r[GEN_EQ_SRC_BIT] && strapDone_r) begin
      eqL1L3_nxt = {strapLevel, strapLevel};
      eqL0L2_nxt = {strapLevel, strapLevel};
    end
  end

  // falling mux upper bit seen at the write edge
  assign muxUpperFall = genCtl_r[GEN_MUX_UPPER_BIT] && !genCtl_nxt[GEN_MUX_UPPER_BIT];

  always_comb begin
    powerState_nxt = powerState_r;
    laneCount_nxt  = laneCount_r;
    // clear, a capture in the same cycle wins
    if (muxUpperFall) begin
      powerState_nxt = 2'h0;
      laneCount_nxt  = 5'h00;
    end
    if (auxPowerWrite) begin
      powerState_nxt = auxPowerData;
    end
    if (auxLaneCountWrite) begin
      laneCount_nxt = auxLaneCountData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      genCtl_r     <= RST_GEN_CTL;
      eqL1L3_r     <= RST_EQ;
      eqL0L2_r     <= RST_EQ;
      laneCtl_r    <= RST_LANE_CTL;
      powerState_r <= 2'h0;
      laneCount_r  <= 5'h00;
    end else begin
      genCtl_r     <= genCtl_nxt;
      eqL1L3_r     <= eqL1L3_nxt;
      eqL0L2_r     <= eqL0L2_nxt;
      laneCtl_r    <= laneCtl_nxt;
      powerState_r <= powerState_nxt;
      laneCount_r  <= laneCount_nxt;
    end
  end

  // ==========================================================
  // lane enables
  logic       dpOn;
  logic [3:0] muxLanes, snoopLanes, laneEn_nxt, laneEn_r;
  logic       usbEn_nxt, usbEn_r;

  assign dpOn = genCtl_r[GEN_DP_EN_SRC_BIT] ? pinSync_r : genCtl_r[GEN_MUX_UPPER_BIT];

  always_comb begin
    muxLanes  = 4'h0;
    usbEn_nxt = 1'b0;
    case (genCtl_r[1:0])
      MUX_OFF:     muxLanes = 4'h0;
      MUX_USB:     usbEn_nxt = 1'b1;
      MUX_DP4:     muxLanes = 4'hF;
      MUX_DP2_USB: begin
        muxLanes  = DP2_LANES;
        usbEn_nxt = 1'b1;
      end
      default:     muxLanes = 4'h0;
    endcase
    // lanes within captured count, zero means not yet trained
    case (laneCount_r)
      5'h00:   snoopLanes = 4'hF;
      5'h01:   snoopLanes = 4'h1;
      5'h02:   snoopLanes = 4'h3;
      5'h03:   snoopLanes = 4'h7;
      default: snoopLanes = 4'hF;
    endcase
    // sink power-down states gate all lanes unless snooping is disabled
    if (powerState_r[1]) begin
      snoopLanes = 4'h0;
    end
    // per-lane off bits when snooping is disabled
    if (laneCtl_r[LANE_SNOOP_DIS_BIT]) begin
      laneEn_nxt = muxLanes & ~laneCtl_r[3:0] & {4{dpOn}};
    end else begin
      laneEn_nxt = muxLanes & snoopLanes & {4{dpOn}};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      laneEn_r <= 4'h0;
      usbEn_r  <= 1'b0;
    end else begin
      laneEn_r <= laneEn_nxt;
      usbEn_r  <= usbEn_nxt;
    end
  end

  // ==========================================================
  // read port
  logic [7:0] rdData_r, rdData_nxt;

  always_comb begin
    rdData_nxt = rdData_r;
    if (regRdEn) begin
      case (regAddr)
        OFS_GEN_CTL:  rdData_nxt = genCtl_r;
        OFS_EQ_L1_L3: rdData_nxt = eqL1L3_r;
        OFS_EQ_L0_L2: rdData_nxt = eqL0L2_r;
        OFS_SNOOPED:  rdData_nxt = {1'b0, powerState_r, laneCount_r};
        OFS_LANE_CTL: rdData_nxt = laneCtl_r;
        default:      rdData_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdData_r <= 8'h00;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  assign lane1EqLevel          = eqL1L3_r[7:4];
  assign lane3EqLevel          = eqL1L3_r[3:0];
  assign lane0EqLevel          = eqL0L2_r[7:4];
  assign lane2EqLevel          = eqL0L2_r[3:0];
  assign eqSourceFromRegisters = genCtl_r[GEN_EQ_SRC_BIT];
  assign hotPlugInputForce     = genCtl_r[GEN_HPD_FORCE_BIT];
  assign orientationSelect     = genCtl_r[GEN_ORIENT_BIT];
  assign muxConfiguration      = genCtl_r[1:0];
  assign dpLaneEnable          = laneEn_r;
  assign usbEnable             = usbEn_r;
  assign regRdData             = rdData_r;

  // ==========================================================
  // assertions
  AST_GEN_RESET: assert property (@(posedge core_clk) !reset_n |=> genCtl_r == RST_GEN_CTL)
    else $error("general control not 0x01 after reset");
  AST_SW_LEVEL: assert property (@(posedge core_clk) disable iff (!reset_n)
    regWrEn && regAddr == OFS_EQ_L0_L2 && genCtl_r[GEN_EQ_SRC_BIT] |=> lane0EqLevel == $past(regWrData[7:4]))
    else $error("written lane 0 level not applied");
  AST_STRAP_MIRROR: assert property (@(posedge core_clk) disable iff (!reset_n)
    !genCtl_r[GEN_EQ_SRC_BIT] && strapDone_r |=> eqL1L3_r == {2{$past(strapLevel)}})
    else $error("lane levels do not follow straps");
  AST_MUX_OFF: assert property (@(posedge core_clk) disable iff (!reset_n)
    genCtl_r[1:0] == MUX_OFF ##1 genCtl_r[1:0] == MUX_OFF |-> dpLaneEnable == 4'h0 && !usbEnable)
    else $error("lanes active with mux off");
  AST_POWER_CAPTURE: assert property (@(posedge core_clk) disable iff (!reset_n)
    auxPowerWrite |=> powerState_r == $past(auxPowerData))
    else $error("power state not captured");
  AST_COUNT_CAPTURE: assert property (@(posedge core_clk) disable iff (!reset_n)
    auxLaneCountWrite |=> laneCount_r == $past(auxLaneCountData))
    else $error("lane count not captured");
  AST_FALL_CLEAR: assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(genCtl_r[GEN_MUX_UPPER_BIT]) && !$past(auxPowerWrite) && !$past(auxLaneCountWrite)
    |-> powerState_r == 2'h0 && laneCount_r == 5'h00)
    else $error("snooped state not cleared on mux fall");
  AST_LANE_OFF: assert property (@(posedge core_clk) disable iff (!reset_n)
    laneCtl_r[LANE_SNOOP_DIS_BIT] |=> (dpLaneEnable & $past(laneCtl_r[3:0])) == 4'h0)
    else $error("disabled lane still enabled");
  AST_COUNT_LIMIT: assert property (@(posedge core_clk) disable iff (!reset_n)
    !laneCtl_r[LANE_SNOOP_DIS_BIT] && laneCount_r == 5'h01 |=> dpLaneEnable[3:1] == 3'h0)
    else $error("lane outside count enabled");
  AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (!reset_n)
    regRdEn && regAddr == OFS_GEN_CTL |=> regRdData[7:5] == 3'h0)
    else $error("reserved bits read nonzero");
  COV_DP4: cover property (@(posedge core_clk) disable iff (!reset_n) dpLaneEnable == 4'hF);
  COV_SNOOP_TWO: cover property (@(posedge core_clk) disable iff (!reset_n)
    auxLaneCountWrite && auxLaneCountData == 5'h02 ##1 genCtl_r[1:0] == MUX_DP4);
  COV_FALL: cover property (@(posedge core_clk) disable iff (!reset_n) muxUpperFall);
endmodule

`default_nettype wire

// ==== rdcs_host_model.sv ====
// host-side model of the sub-address register port behind the serial target
`timescale 1ns/1ps
`default_nettype none

module rdcs_host_model (
  input  wire logic       core_clk,
  output logic      [7:0] regAddr,
  output logic            regWrEn,
  output logic      [7:0] regWrData,
  output logic            regRdEn
);
  initial begin
    regAddr   = 8'h00;
    regWrEn   = 1'b0;
    regWrData = 8'h00;
    regRdEn   = 1'b0;
  end

  // ==========================================================
  // single byte access
  // one-byte sub-address
  task automatic access(input logic [7:0] addr, input logic [7:0] data, input logic wr);
    @(posedge core_clk);
    regAddr   <= addr;
    regWrData <= data;
    regWrEn   <= wr;
    regRdEn   <= ~wr;
    @(posedge core_clk);
    regWrEn   <= 1'b0;
    regRdEn   <= 1'b0;
    // released bus shows no stale values
    regAddr   <= ~addr;
    regWrData <= ~data;
  endtask
endmodule

`default_nettype wire

// ==== rdcs_config_snoop_regs_tb.sv ====
// self-checking bench for the redriver configuration and snoop register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module rdcs_config_snoop_regs_tb;
  import rdcs_pkg::*;
  logic       core_clk = 1'b0;
  logic       reset_n  = 1'b0;
  logic [7:0] regAddr, regWrData, regRdData, rv, expV;
  logic       regWrEn, regRdEn, usbEnable, orientationSelect, hotPlugInputForce, eqSourceFromRegisters;
  logic       rdSeen = 1'b0;
  logic [1:0] displayportEqStraps, auxPowerData, muxConfiguration, sv;
  logic       displayportControlPin, auxPowerWrite, auxLaneCountWrite;
  logic [4:0] auxLaneCountData;
  logic [3:0] lane0EqLevel, lane1EqLevel, lane2EqLevel, lane3EqLevel, dpLaneEnable;
  logic [7:0] expQ[$];
  int         fails, numChecks, i;

  always #12.5 core_clk = ~core_clk;

  rdcs_host_model rdcs_host_model_i (.core_clk(core_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn));

  rdcs_config_snoop_regs rdcs_config_snoop_regs_i (.core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .displayportEqStraps(displayportEqStraps), .displayportControlPin(displayportControlPin),
    .auxPowerWrite(auxPowerWrite), .auxPowerData(auxPowerData), .auxLaneCountWrite(auxLaneCountWrite),
    .auxLaneCountData(auxLaneCountData), .muxConfiguration(muxConfiguration), .orientationSelect(orientationSelect),
    .hotPlugInputForce(hotPlugInputForce), .eqSourceFromRegisters(eqSourceFromRegisters), .usbEnable(usbEnable),
    .lane0EqLevel(lane0EqLevel), .lane1EqLevel(lane1EqLevel), .lane2EqLevel(lane2EqLevel),
    .lane3EqLevel(lane3EqLevel), .dpLaneEnable(dpLaneEnable));

  // ==========================================================
  // helpers
  task automatic results();
    if (fails == 0 && numChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rdcs_host_model_i.access(a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    rdcs_host_model_i.access(a, 8'h00, 1'b0);
  endtask

  task automatic snoop(input logic pw, input logic [1:0] pd, input logic lw, input logic [4:0] ld);
    @(posedge core_clk);
    auxPowerWrite     <= pw;
    auxPowerData      <= pd;
    auxLaneCountWrite <= lw;
    auxLaneCountData  <= ld;
    @(posedge core_clk);
    auxPowerWrite     <= 1'b0;
    auxLaneCountWrite <= 1'b0;
    waitc(3);
  endtask

  function automatic logic [3:0] cntLanes(input int n);
    return (n == 0 || n >= 4) ? 4'hF : 4'((1 << n) - 1);
  endfunction

  // ==========================================================
  // read-data monitor: oldest expectation against each answer
  always @(posedge core_clk) begin
    if (rdSeen && expQ.size() > 0) begin
      expV = expQ.pop_front();
      `CHK(regRdData, expV)
    end
    rdSeen <= regRdEn;
  end

  initial begin
    #(25 * 4000);
    fails++;
    results();
  end

  // ==========================================================
  // main sequence
  initial begin
    fails = 0;
    numChecks = 0;
    displayportEqStraps = 2'h0;
    displayportControlPin = 1'b0;
    auxPowerWrite = 1'b0;
    auxPowerData = 2'h0;
    auxLaneCountWrite = 1'b0;
    auxLaneCountData = 5'h0;
    void'($urandom(64));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    waitc(1);
    `CHK(muxConfiguration, MUX_USB)
    `CHK(orientationSelect, 1'b0)
    rd(OFS_GEN_CTL, RST_GEN_CTL);
    rd(OFS_EQ_L1_L3, RST_EQ);
    rd(OFS_EQ_L0_L2, RST_EQ);
    rd(OFS_SNOOPED, 8'h00);
    rd(OFS_LANE_CTL, RST_LANE_CTL);
    `CHK(usbEnable, 1'b1)
    // mid-run reset with straps set: they are sampled once after release
    wr(OFS_GEN_CTL, 8'h1E);
    sv = 2'($urandom_range(3, 1));
    @(posedge core_clk);
    displayportEqStraps <= sv;
    reset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    waitc(1);
    `CHK(muxConfiguration, MUX_USB)
    `CHK(eqSourceFromRegisters, 1'b0)
    // strap mirroring overwrites software values
    wr(OFS_EQ_L1_L3, 8'hAB);
    waitc(6);
    rd(OFS_EQ_L1_L3, {2'b00, sv, 2'b00, sv});
    rd(OFS_EQ_L0_L2, {2'b00, sv, 2'b00, sv});
    `CHK(lane3EqLevel, {2'b00, sv})
    // reserved, read-only and unmapped places
    wr(OFS_GEN_CTL, 8'hFF);
    rd(OFS_GEN_CTL, RW_GEN_CTL);
    `CHK(orientationSelect, 1'b1)
    wr(OFS_SNOOPED, 8'hFF);
    rd(OFS_SNOOPED, 8'h00);
    wr(OFS_LANE_CTL, 8'hFF);
    rd(OFS_LANE_CTL, RW_LANE_CTL);
    rd(8'h55, 8'h00);
    // programmed levels hold against strap changes
    wr(OFS_LANE_CTL, 8'h00);
    wr(OFS_GEN_CTL, 8'h12);
    @(posedge core_clk);
    displayportEqStraps <= ~sv;
    for (i = 0; i < 3; i++) begin
      rv = 8'($urandom);
      wr(OFS_EQ_L1_L3, rv);
      wr(OFS_EQ_L0_L2, ~rv);
      waitc(6);
      rd(OFS_EQ_L1_L3, rv);
      `CHK({lane1EqLevel, lane3EqLevel}, rv)
      `CHK({lane0EqLevel, lane2EqLevel}, ~rv)
      `CHK(eqSourceFromRegisters, 1'b1)
    end
    // every mux code
    for (i = 0; i < 4; i++) begin
      wr(OFS_GEN_CTL, 8'h10 | 8'(i));
      waitc(3);
      `CHK(muxConfiguration, 2'(i))
      `CHK(usbEnable, 1'(i & 1))
      `CHK(dpLaneEnable, (i == 2) ? 4'hF : (i == 3) ? DP2_LANES : 4'h0)
    end
    // snooped lane count and power state
    wr(OFS_GEN_CTL, 8'h12);
    for (i = 0; i < 6; i++) begin
      snoop(1'b0, 2'h0, 1'b1, 5'(i));
      `CHK(dpLaneEnable, cntLanes(i))
      rd(OFS_SNOOPED, 8'(i));
    end
    snoop(1'b1, 2'h2, 1'b0, 5'h0);
    `CHK(dpLaneEnable, 4'h0)
    rd(OFS_SNOOPED, 8'h45);
    snoop(1'b1, 2'h1, 1'b1, 5'h2);
    `CHK(dpLaneEnable, 4'h3)
    rd(OFS_SNOOPED, 8'h22);
    // falling mux upper bit clears the captures
    wr(OFS_GEN_CTL, 8'h11);
    rd(OFS_SNOOPED, 8'h00);
    wr(OFS_GEN_CTL, 8'h12);
    waitc(3);
    `CHK(dpLaneEnable, 4'hF)
    // snooping off: per-lane off bits rule
    wr(OFS_LANE_CTL, 8'h85);
    snoop(1'b0, 2'h0, 1'b1, 5'h1);
    `CHK(dpLaneEnable, 4'hA)
    // enable taken from the control pin
    wr(OFS_GEN_CTL, 8'h1A);
    waitc(4);
    `CHK(dpLaneEnable, 4'h0)
    `CHK(hotPlugInputForce, 1'b1)
    @(posedge core_clk);
    displayportControlPin <= 1'b1;
    waitc(6);
    `CHK(dpLaneEnable, 4'hA)
    waitc(3);
    results();
  end
endmodule

`default_nettype wire
